/* hcc_chan_ctrl.sv */
// High-speed channel control register with rate selection and sync monitor
`timescale 1ns/100ps
// What this block does
// [RQ1] Override clear: multipliers and lane rates derived from selected reference frequency.
// [RQ2] Override set: multipliers and rates taken from the external manual fields.
// [RQ3] Frequency bit picks 156.25 MHz (0) or 312.5 MHz (1) reference.
// [RQ4] Receive skip bit disables receive clock tolerance compensation.
// [RQ5] Transmit skip bit disables transmit clock tolerance compensation.
// [RQ6] Encoder skip bit bypasses the high-side 8b/10b encoder.
// [RQ7] Decoder skip bit bypasses the high-side 8b/10b decoder.
// [RQ8] Policy 00 applies standard Ethernet hysteresis before losing sync.
// [RQ9] Policy 01: one code or disparity error drops sync at once.
// [RQ10] Policy 10: two adjacent errors drop sync at once.
// [RQ11] Policy 11: three adjacent errors drop sync at once.
// [RQ12] Whole register resets to zero.
// [RQ13] Host reads and writes the register as one 16-bit word.
module hcc_chan_ctrl
  import hcc_pkg::*;
#(
  parameter int              MULT_W     = 8,
  parameter int              RATE_W     = 4,
  parameter logic [MULT_W-1:0] HS_MULT_156 = 8'h40,
  parameter logic [MULT_W-1:0] HS_MULT_312 = 8'h20,
  parameter logic [MULT_W-1:0] LS_MULT_156 = 8'h10,
  parameter logic [MULT_W-1:0] LS_MULT_312 = 8'h08,
  parameter logic [RATE_W-1:0] RATE_156    = 4'h1,
  parameter logic [RATE_W-1:0] RATE_312    = 4'h2
)
(
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  // Management register access
  input  wire logic              MGMT_WE,
  input  wire logic              MGMT_RE,
  input  wire logic [4:0]        MGMT_DEVAD,
  input  wire logic [15:0]       MGMT_REGAD,
  input  wire logic [15:0]       MGMT_WDATA,
  output logic      [15:0]       MGMT_RDATA,
  // Manual rate fields from other configuration registers
  input  wire logic [MULT_W-1:0] MAN_HIGH_SIDE_PLL_MULTIPLIER,
  input  wire logic [MULT_W-1:0] MAN_LS_MULT,
  input  wire logic [RATE_W-1:0] MAN_LANE_RATE,
  // Applied rate settings
  output logic      [MULT_W-1:0] HIGH_SIDE_PLL_MULTIPLIER,
  output logic      [MULT_W-1:0] LOW_SIDE_MULTIPLIER,
  output logic      [RATE_W-1:0] LANE_RATE,
  // Datapath controls
  output logic                   RX_RATE_COMP_SKIP,
  output logic                   TX_RATE_COMP_SKIP,
  output logic                   HIGH_SIDE_ENCODER_SKIP,
  output logic                   HIGH_SIDE_DECODER_SKIP,
  // Receive code stream and sync status
  input  wire logic              HS_CODE_VALID,
  input  wire logic              HS_CODE_ERR,
  output logic                   HS_IN_SYNC
);
  typedef struct packed {
    logic [15:0]       ctrl;
    logic [15:0]       rdata;
    logic [MULT_W-1:0] hs_mult;
    logic [MULT_W-1:0] ls_mult;
    logic [RATE_W-1:0] rate;
  } hcc_main_t;

  hcc_main_t q;
  hcc_main_t next_q;
  logic      hit;

  // ****************************************
  // Register access and rate selection
  // ****************************************
  assign hit = (MGMT_DEVAD == HCC_DEV_ADDR) && (MGMT_REGAD == HCC_REG_ADDR);

  always_comb
  begin
    next_q = q;
    // All writable fields change together in one write
    if (MGMT_WE && hit)
      next_q.ctrl = MGMT_WDATA & HCC_WMASK; // see [RQ13]
    // Read data is registered, so the answer stands from the cycle after the strobe
    if (MGMT_RE)
      next_q.rdata = hit ? q.ctrl : 16'h0000; // see [RQ13]
    // Settings follow the register one cycle later, so a write never glitches them
    if (q.ctrl[HCC_RATE_OVR_BIT])
    begin
      next_q.hs_mult = MAN_HIGH_SIDE_PLL_MULTIPLIER; // see [RQ2]
      next_q.ls_mult = MAN_LS_MULT;
      next_q.rate    = MAN_LANE_RATE;
    end
    else if (q.ctrl[HCC_FREQ_BIT])
    begin
      next_q.hs_mult = HS_MULT_312; // see [RQ1] see [RQ3]
      next_q.ls_mult = LS_MULT_312;
      next_q.rate    = RATE_312;
    end
    else
    begin
      next_q.hs_mult = HS_MULT_156; // see [RQ1] see [RQ3]
      next_q.ls_mult = LS_MULT_156;
      next_q.rate    = RATE_156;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      q.ctrl    <= HCC_RESET; // see [RQ12]
      q.rdata   <= HCC_RESET;
      q.hs_mult <= HS_MULT_156;
      q.ls_mult <= LS_MULT_156;
      q.rate    <= RATE_156;
    end
    else
      q <= next_q;
  end

  assign MGMT_RDATA               = q.rdata;
  assign HIGH_SIDE_PLL_MULTIPLIER = q.hs_mult;
  assign LOW_SIDE_MULTIPLIER      = q.ls_mult;
  assign LANE_RATE                = q.rate;
  assign RX_RATE_COMP_SKIP        = q.ctrl[HCC_RX_SKIP_BIT]; // see [RQ4]
  assign TX_RATE_COMP_SKIP        = q.ctrl[HCC_TX_SKIP_BIT]; // see [RQ5]
  assign HIGH_SIDE_ENCODER_SKIP   = q.ctrl[HCC_ENC_SKIP_BIT]; // see [RQ6]
  assign HIGH_SIDE_DECODER_SKIP   = q.ctrl[HCC_DEC_SKIP_BIT]; // see [RQ7]

  // ****************************************
  // Sync monitor
  // ****************************************
  hcc_sync_fsm u_sync (
    .clk        (SYS_CLK),
    .rst        (RST),
    .code_valid (HS_CODE_VALID),
    .code_err   (HS_CODE_ERR),
    .policy     (q.ctrl[HCC_POL_HI:HCC_POL_LO]),
    .in_sync    (HS_IN_SYNC)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence wr_word(logic [15:0] d);
    MGMT_WE && hit && MGMT_WDATA == d;
  endsequence

  sequence wr_then_rd;
    (MGMT_WE && hit && !MGMT_RE) ##1 (MGMT_RE && hit && !MGMT_WE);
  endsequence

  a_auto_rate_156: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ1]
    (!q.ctrl[HCC_RATE_OVR_BIT] && !q.ctrl[HCC_FREQ_BIT]) |=> (HIGH_SIDE_PLL_MULTIPLIER == HS_MULT_156
      && LOW_SIDE_MULTIPLIER == LS_MULT_156 && LANE_RATE == RATE_156))
    else $error("Automatic 156.25 MHz settings not applied");
  a_auto_rate_312: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ3]
    (!q.ctrl[HCC_RATE_OVR_BIT] && q.ctrl[HCC_FREQ_BIT]) |=> (HIGH_SIDE_PLL_MULTIPLIER == HS_MULT_312
      && LOW_SIDE_MULTIPLIER == LS_MULT_312 && LANE_RATE == RATE_312))
    else $error("Automatic 312.5 MHz settings not applied");
  a_manual_rate: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ2]
    q.ctrl[HCC_RATE_OVR_BIT] |=> (HIGH_SIDE_PLL_MULTIPLIER == $past(MAN_HIGH_SIDE_PLL_MULTIPLIER)
      && LOW_SIDE_MULTIPLIER == $past(MAN_LS_MULT) && LANE_RATE == $past(MAN_LANE_RATE)))
    else $error("Manual rate fields not applied");
  a_skip_bits: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ4] see [RQ5]
    wr_word(MGMT_WDATA) |=> (RX_RATE_COMP_SKIP == $past(MGMT_WDATA[HCC_RX_SKIP_BIT])
      && TX_RATE_COMP_SKIP == $past(MGMT_WDATA[HCC_TX_SKIP_BIT])))
    else $error("Compensation skip bits do not follow the write");
  a_codec_bits: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ6] see [RQ7]
    wr_word(MGMT_WDATA) |=> (HIGH_SIDE_ENCODER_SKIP == $past(MGMT_WDATA[HCC_ENC_SKIP_BIT])
      && HIGH_SIDE_DECODER_SKIP == $past(MGMT_WDATA[HCC_DEC_SKIP_BIT])))
    else $error("Encoder or decoder skip bits do not follow the write");
  a_write_readback: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ13]
    wr_then_rd |=> MGMT_RDATA == ($past(MGMT_WDATA, 2) & HCC_WMASK))
    else $error("Read does not return the last written word");
  a_reset_zero: assert property (@(posedge SYS_CLK) // see [RQ12]
    $fell(RST) |-> (q.ctrl == HCC_RESET && !HS_IN_SYNC))
    else $error("Register not zero after reset");
  a_unmapped_read: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ13]
    (MGMT_RE && !hit) |=> MGMT_RDATA == 16'h0000)
    else $error("Unmapped read did not return zero");

  // ****************************************
  // Hold, decode and reset checks
  // ****************************************
  // Outputs must not drift between host accesses, or a datapath retunes on its own
  sequence no_write;
    !(MGMT_WE && hit);
  endsequence

  a_write_lands: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ13]
    (MGMT_WE && hit) |=> q.ctrl == ($past(MGMT_WDATA) & HCC_WMASK))
    else $error("Write did not update the whole word");
  a_ctrl_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ13]
    no_write |=> $stable(q.ctrl))
    else $error("Register changed without a write");
  a_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ13]
    !MGMT_RE |=> $stable(MGMT_RDATA))
    else $error("Read data changed without a read");
  a_unimpl_zero: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ13]
    MGMT_RE |=> (MGMT_RDATA & ~HCC_WMASK) == 16'h0000)
    else $error("Unimplemented bits read back as one");
  a_read_old_word: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ13]
    (MGMT_WE && MGMT_RE && hit) |=> MGMT_RDATA == $past(q.ctrl))
    else $error("Read in a write cycle did not return the old word");
  a_skip_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ4] see [RQ5]
    no_write |=> $stable({RX_RATE_COMP_SKIP, TX_RATE_COMP_SKIP}))
    else $error("Compensation skip bits changed without a write");
  a_codec_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ6] see [RQ7]
    no_write |=> $stable({HIGH_SIDE_ENCODER_SKIP, HIGH_SIDE_DECODER_SKIP}))
    else $error("Codec skip bits changed without a write");
  a_rate_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // see [RQ1]
    ($stable(q.ctrl) && !q.ctrl[HCC_RATE_OVR_BIT])
      |=> $stable({HIGH_SIDE_PLL_MULTIPLIER, LOW_SIDE_MULTIPLIER, LANE_RATE}))
    else $error("Automatic settings moved with a steady register");
  // Checked from the second reset cycle; the first one may still show power-up values
  a_reset_values: assert property (@(posedge SYS_CLK) // see [RQ12]
    (RST && $past(RST)) |-> (q.ctrl == HCC_RESET && MGMT_RDATA == 16'h0000
      && HIGH_SIDE_PLL_MULTIPLIER == HS_MULT_156 && LANE_RATE == RATE_156))
    else $error("Reset values not held during reset");
  a_reset_skips: assert property (@(posedge SYS_CLK) // see [RQ12]
    (RST && $past(RST)) |-> ({RX_RATE_COMP_SKIP, TX_RATE_COMP_SKIP, HIGH_SIDE_ENCODER_SKIP,
      HIGH_SIDE_DECODER_SKIP} == 4'h0 && !HS_IN_SYNC))
    else $error("Controls or sync status not cleared during reset");
endmodule : hcc_chan_ctrl

/* hcc_host_model.sv */
// Management host model that drives the channel control register strobes
`timescale 1ns/100ps
module hcc_host_model
  import hcc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register strobes
  output logic             we,
  output logic             re,
  output logic [4:0]       devad,
  output logic [15:0]      regad,
  output logic [15:0]      wdata,
  // Read return
  input  wire logic [15:0] rdata
);
  initial
  begin
    we    = 1'b0;
    re    = 1'b0;
    devad = 5'h00;
    regad = 16'h0000;
    wdata = 16'h0000;
  end

  // One-cycle write strobe; data is inverted after, so a stale word never looks valid
  task automatic wr(input logic [4:0] d, input logic [15:0] a, input logic [15:0] val);
    @(posedge clk);
    we    <= 1'b1;
    devad <= d;
    regad <= a;
    wdata <= val;
    @(posedge clk);
    we    <= 1'b0;
    wdata <= ~val;
  endtask : wr

  // One-cycle read strobe; the answer is registered, so it is taken an edge later
  task automatic rd(input logic [4:0] d, input logic [15:0] a, output logic [15:0] val);
    @(posedge clk);
    re    <= 1'b1;
    devad <= d;
    regad <= a;
    @(posedge clk);
    re    <= 1'b0;
    @(posedge clk);
    #1;
    val = rdata;
  endtask : rd

  // Write and read in one strobe, then a write and a read back to back
  task automatic wr_rd(input logic [4:0] d, input logic [15:0] a, input logic [15:0] v1,
                       input logic [15:0] v2, output logic [15:0] old_val, output logic [15:0] new_val);
    @(posedge clk);
    we    <= 1'b1;
    re    <= 1'b1;
    devad <= d;
    regad <= a;
    wdata <= v1;
    @(posedge clk);
    re    <= 1'b0;
    wdata <= v2;
    #1;
    old_val = rdata;
    @(posedge clk);
    we    <= 1'b0;
    re    <= 1'b1;
    wdata <= ~v2;
    @(posedge clk);
    re    <= 1'b0;
    #1;
    new_val = rdata;
  endtask : wr_rd
endmodule : hcc_host_model

/* hcc_pkg.sv */
// Constants for the high-speed channel control register block
package hcc_pkg;
  localparam logic [4:0]  HCC_DEV_ADDR      = 5'h1E;
  localparam logic [15:0] HCC_REG_ADDR      = 16'h001D;
  localparam logic [15:0] HCC_RESET         = 16'h0000;
  // Bits 9:8 are not implemented and read as zero
  localparam logic [15:0] HCC_WMASK         = 16'hFCFF;
  localparam int          HCC_RATE_OVR_BIT  = 13;
  localparam int          HCC_FREQ_BIT      = 12;
  localparam int          HCC_RX_SKIP_BIT   = 11;
  localparam int          HCC_TX_SKIP_BIT   = 10;
  localparam int          HCC_ENC_SKIP_BIT  = 3;
  localparam int          HCC_DEC_SKIP_BIT  = 2;
  localparam int          HCC_POL_HI        = 1;
  localparam int          HCC_POL_LO        = 0;
  localparam logic [1:0]  HCC_POL_STD       = 2'h0;
  localparam logic [1:0]  HCC_POL_ONE       = 2'h1;
  localparam logic [1:0]  HCC_POL_TWO       = 2'h2;
  localparam logic [1:0]  HCC_POL_THREE     = 2'h3;
  // Sync acquisition and standard hysteresis counts
  localparam logic [1:0]  HCC_ACQ_LAST      = 2'h2;
  localparam logic [2:0]  HCC_LOSS_LAST     = 3'h3;
  localparam logic [1:0]  HCC_GOOD_RUN_LAST = 2'h3;
  localparam logic [1:0]  HCC_ZERO2         = 2'h0;
  localparam logic [2:0]  HCC_ZERO3         = 3'h0;
  localparam logic [1:0]  HCC_ONE2          = 2'h1;
  localparam logic [2:0]  HCC_ONE3          = 3'h1;
endpackage : hcc_pkg

/* hcc_sync_fsm.sv */
// High-speed receive channel synchronization state machine
`timescale 1ns/100ps
module hcc_sync_fsm
  import hcc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Code group stream
  input  wire logic       code_valid,
  input  wire logic       code_err,
  input  wire logic [1:0] policy,
  // Status
  output logic            in_sync
);
  typedef enum logic {HCC_S_UNSYNC, HCC_S_SYNC} hcc_sync_st_t;
  typedef struct packed {
    hcc_sync_st_t st;
    logic [1:0]   acq;
    logic [1:0]   err_run;
    logic [2:0]   bad_level;
    logic [1:0]   good_run;
  } hcc_sync_t;

  hcc_sync_t q;
  hcc_sync_t next_q;

  always_comb
  begin
    next_q = q;
    if (code_valid)
    begin
      unique case (q.st)
        HCC_S_UNSYNC:
        begin
          if (code_err)
            next_q.acq = HCC_ZERO2;
          else if (q.acq == HCC_ACQ_LAST)
          begin
            next_q.st        = HCC_S_SYNC;
            next_q.acq       = HCC_ZERO2;
            next_q.err_run   = HCC_ZERO2;
            next_q.bad_level = HCC_ZERO3;
            next_q.good_run  = HCC_ZERO2;
          end
          else
            next_q.acq = q.acq + HCC_ONE2;
        end
        HCC_S_SYNC:
        begin
          if (policy == HCC_POL_STD)
          begin
            // Errors build a level that good runs wear down again
            if (code_err)
            begin
              next_q.good_run = HCC_ZERO2;
              if (q.bad_level == HCC_LOSS_LAST)
                next_q.st = HCC_S_UNSYNC; // see [RQ8]
              else
                next_q.bad_level = q.bad_level + HCC_ONE3;
            end
            else if (q.bad_level != HCC_ZERO3)
            begin
              if (q.good_run == HCC_GOOD_RUN_LAST)
              begin
                next_q.bad_level = q.bad_level - HCC_ONE3;
                next_q.good_run  = HCC_ZERO2;
              end
              else
                next_q.good_run = q.good_run + HCC_ONE2;
            end
          end
          else
          begin
            // Policy code equals the number of adjacent errors that drops sync
            if (code_err)
            begin
              // A run left over from a larger policy must not outlive a switch to a smaller one
              if (({1'b0, q.err_run} + HCC_ONE3) >= {1'b0, policy})
                next_q.st = HCC_S_UNSYNC; // see [RQ9] see [RQ10] see [RQ11]
              else
                next_q.err_run = q.err_run + HCC_ONE2;
            end
            else
              next_q.err_run = HCC_ZERO2;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '{HCC_S_UNSYNC, HCC_ZERO2, HCC_ZERO2, HCC_ZERO3, HCC_ZERO2};
    else
      q <= next_q;
  end

  assign in_sync = (q.st == HCC_S_SYNC);

  // ****************************************
  // Checks
  // ****************************************
  sequence bad_in_sync(logic [1:0] p);
    in_sync && policy == p && code_valid && code_err;
  endsequence

  a_std_first_err: assert property (@(posedge clk) disable iff (rst) // see [RQ8]
    (in_sync && policy == HCC_POL_STD && q.bad_level == HCC_ZERO3 && code_valid && code_err) |=> in_sync)
    else $error("Standard hysteresis lost sync on a first error");
  a_single_err_loss: assert property (@(posedge clk) disable iff (rst) // see [RQ9]
    bad_in_sync(HCC_POL_ONE) |=> !in_sync)
    else $error("Single error did not drop sync");
  a_two_err_loss: assert property (@(posedge clk) disable iff (rst) // see [RQ10]
    bad_in_sync(HCC_POL_TWO) ##1 bad_in_sync(HCC_POL_TWO) |=> !in_sync)
    else $error("Two adjacent errors did not drop sync");
  a_three_err_loss: assert property (@(posedge clk) disable iff (rst) // see [RQ11]
    bad_in_sync(HCC_POL_THREE) ##1 bad_in_sync(HCC_POL_THREE) ##1 bad_in_sync(HCC_POL_THREE) |=> !in_sync)
    else $error("Three adjacent errors did not drop sync");
  a_three_err_hold: assert property (@(posedge clk) disable iff (rst) // see [RQ11]
    (bad_in_sync(HCC_POL_THREE) and (q.err_run == HCC_ZERO2)) |=> in_sync)
    else $error("Three-error policy dropped sync too early");
endmodule : hcc_sync_fsm

/* testbench.sv */
// Self-checking testbench for the high-speed channel control register
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t bad %h", $time, a); end end
module testbench;
  import hcc_pkg::*;
  logic        clk, rst, we, re, cv, ce, rx, tx, enc, dec, ins;
  logic [4:0]  devad;
  logic [15:0] regad, wdata, rdata, v, w;
  logic [7:0]  mhs, mls, hs, ls;
  logic [3:0]  mlr, lr;
  int          fails, n_tests, cyc;

  hcc_host_model u_hcc_host_model (.clk(clk), .we(we), .re(re), .devad(devad), .regad(regad),
    .wdata(wdata), .rdata(rdata));
  hcc_chan_ctrl u_hcc_chan_ctrl (.SYS_CLK(clk), .RST(rst), .MGMT_WE(we), .MGMT_RE(re),
    .MGMT_DEVAD(devad), .MGMT_REGAD(regad), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata),
    .MAN_HIGH_SIDE_PLL_MULTIPLIER(mhs), .MAN_LS_MULT(mls), .MAN_LANE_RATE(mlr), .HIGH_SIDE_PLL_MULTIPLIER(hs),
    .LOW_SIDE_MULTIPLIER(ls), .LANE_RATE(lr), .RX_RATE_COMP_SKIP(rx), .TX_RATE_COMP_SKIP(tx),
    .HIGH_SIDE_ENCODER_SKIP(enc), .HIGH_SIDE_DECODER_SKIP(dec), .HS_CODE_VALID(cv),
    .HS_CODE_ERR(ce), .HS_IN_SYNC(ins));

  // ************
  // Scenarios
  // ************
  task automatic chk_rates(input logic [7:0] h, input logic [7:0] l, input logic [3:0] r);
    `CHK(hs, h)
    `CHK(ls, l)
    `CHK(lr, r)
  endtask : chk_rates

  task automatic t_reset;
    u_hcc_host_model.rd(HCC_DEV_ADDR, HCC_REG_ADDR, v);
    `CHK(v, HCC_RESET)
    `CHK({rx, tx, enc, dec, ins}, 5'h00)
    chk_rates(8'h40, 8'h10, 4'h1);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_fields;
    u_hcc_host_model.wr(HCC_DEV_ADDR, HCC_REG_ADDR, 16'hFFFF);
    u_hcc_host_model.rd(HCC_DEV_ADDR, HCC_REG_ADDR, v);
    `CHK(v, 16'hFCFF)
    `CHK(rx, 1'b1)
    `CHK(tx, 1'b1)
    `CHK(enc, 1'b1)
    `CHK(dec, 1'b1)
    chk_rates(mhs, mls, mlr);
    u_hcc_host_model.wr(HCC_DEV_ADDR, HCC_REG_ADDR, 16'h1000);
    u_hcc_host_model.rd(HCC_DEV_ADDR, HCC_REG_ADDR, v);
    `CHK(v, 16'h1000)
    `CHK({rx, tx, enc, dec}, 4'h0)
    chk_rates(8'h20, 8'h08, 4'h2);
    $display("t_fields done");
  endtask : t_fields

  // Writes to a neighbour register or another device must leave this word alone
  task automatic t_unmapped;
    u_hcc_host_model.wr(HCC_DEV_ADDR, 16'h001C, 16'h2C0C);
    u_hcc_host_model.wr(5'h1F, HCC_REG_ADDR, 16'h2C0C);
    u_hcc_host_model.rd(HCC_DEV_ADDR, HCC_REG_ADDR, v);
    `CHK(v, 16'h1000)
    u_hcc_host_model.rd(HCC_DEV_ADDR, 16'h001C, v);
    `CHK(v, 16'h0000)
    $display("t_unmapped done");
  endtask : t_unmapped

  // A read in a write cycle sees the old word; a read right after a write sees the new one
  task automatic t_same_cycle;
    u_hcc_host_model.wr_rd(HCC_DEV_ADDR, HCC_REG_ADDR, 16'hC0F0, 16'h2308, v, w);
    `CHK(v, 16'h1000)
    `CHK(w, 16'h2008)
    `CHK({rx, tx, enc, dec}, 4'h2)
    chk_rates(mhs, mls, mlr);
    $display("t_same_cycle done");
  endtask : t_same_cycle

  // A reset in mid-run must bring back the power-up word and defaults
  task automatic t_mid_reset;
    u_hcc_host_model.wr(HCC_DEV_ADDR, HCC_REG_ADDR, 16'hFFFF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    $display("t_mid_reset done");
  endtask : t_mid_reset

  // Idle cycles between groups must not break an error run
  task automatic send(input int n, input logic e);
    repeat (n)
    begin
      @(posedge clk);
      cv <= 1'b1;
      ce <= e;
    end
    @(posedge clk);
    cv <= 1'b0;
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : send

  task automatic t_sync;
    int n;
    for (int p = 0; p < 4; p++)
    begin
      n = (p == 0) ? 4 : p;
      u_hcc_host_model.wr(HCC_DEV_ADDR, HCC_REG_ADDR, {14'h0000, p[1:0]});
      send(3, 1'b0);
      `CHK(ins, 1'b1)
      if (p > 1)
      begin
        send(n - 1, 1'b1);
        send(1, 1'b0);
      end
      send(n - 1, 1'b1);
      `CHK(ins, 1'b1)
      send(1, 1'b1);
      `CHK(ins, 1'b0)
      // Same loss again with the errors on consecutive cycles
      send(3, 1'b0);
      `CHK(ins, 1'b1)
      send(n, 1'b1);
      `CHK(ins, 1'b0)
    end
    $display("t_sync done");
  endtask : t_sync

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // ************
  // Clock, timeout and sequence
  // ************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The whole run needs under two hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      print_verdict;
    end
  end

  initial
  begin
    rst = 1'b1;
    cv  = 1'b0;
    ce  = 1'b0;
    mhs = 8'hA5;
    mls = 8'h5A;
    mlr = 4'h9;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_fields;
    t_unmapped;
    t_same_cycle;
    t_sync;
    t_mid_reset;
    print_verdict;
  end
endmodule : testbench
